// [design/error_log_pkg.sv]
package error_log_pkg;

    localparam int CODE_W = 11;
    localparam int DEPTH = 30;
    localparam int PTR_W = 5;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int NSRC = 10;

    typedef logic signed [CODE_W-1:0] code_t;

    typedef struct packed {
        logic valid;
        logic viewed;
        code_t code;
    } entry_t;

    typedef struct packed {
        logic valid;
        code_t code;
    } post_t;

    // Register offsets (word index on the plain port)
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_VIEW = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_ESR = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_POP = 4'h4;

    // Control bits, write-one actions
    localparam int CTRL_NEXT = 0;
    localparam int CTRL_PREV = 1;
    localparam int CTRL_CLEAR = 2;

    // Event status register bits
    localparam int ESR_W = 8;
    localparam logic [ESR_W-1:0] ESR_RESET = 8'h00;
    localparam int ESR_QUERY = 2;
    localparam int ESR_DEVICE = 3;
    localparam int ESR_EXEC = 4;
    localparam int ESR_CMD = 5;

    // Code ranges per class
    localparam code_t QUERY_LO = -11'sd499;
    localparam code_t QUERY_HI = -11'sd400;
    localparam code_t DEV_NEG_LO = -11'sd399;
    localparam code_t DEV_NEG_HI = -11'sd300;
    localparam code_t DEV_POS_LO = 11'sd201;
    localparam code_t DEV_POS_HI = 11'sd703;
    localparam code_t DEV_HIGH_LO = 11'sd800;
    localparam code_t DEV_HIGH_HI = 11'sd810;
    localparam code_t EXEC_LO = -11'sd299;
    localparam code_t EXEC_HI = -11'sd200;
    localparam code_t CMD_LO = -11'sd199;
    localparam code_t CMD_HI = -11'sd100;

    // No-error code, then the codes posted by the internal detectors
    localparam code_t CODE_NO_ERROR = 11'sd0;
    localparam code_t CODE_SELFTEST = -11'sd330;
    localparam code_t CODE_QUERY_EMPTY = -11'sd420;
    localparam code_t CODE_QUERY_LOST = -11'sd410;
    localparam code_t CODE_EXEC_RANGE = -11'sd222;
    localparam code_t CODE_EXEC_STATE = -11'sd221;
    localparam code_t CODE_CMD_SYNTAX = -11'sd102;
    localparam code_t CODE_CMD_DATATYPE = -11'sd104;
    localparam code_t CODE_CMD_HEADER = -11'sd113;

    // Fixed-point parameter format for the range check
    localparam int PARAM_W = 16;
    localparam int FRAC_W = 4;
    localparam logic signed [PARAM_W-1:0] PARAM_HALF = 16'sh0008;

endpackage : error_log_pkg

// [design/error_queue_status_logger.sv]
`timescale 1ns/1ps

module error_queue_status_logger
    import error_log_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic err_valid,
    input wire code_t err_code,
    input wire logic selftest_fail,
    input wire logic query_empty_read,
    input wire logic query_data_lost,
    input wire logic param_check,
    input wire logic signed [PARAM_W-1:0] param_raw,
    input wire logic signed [PARAM_W-1:0] param_min,
    input wire logic signed [PARAM_W-1:0] param_max,
    input wire logic exec_state_err,
    input wire logic cmd_syntax_err,
    input wire logic cmd_type_err,
    input wire logic cmd_header_err,
    input wire logic unresolved,
    input wire code_t unresolved_code,
    output logic [DATA_W-1:0] rdata,
    output logic err_indicator,
    output logic [ESR_W-1:0] esr,
    output post_t remote_post
);

    entry_t mem [DEPTH];
    entry_t next_mem [DEPTH];
    logic [PTR_W-1:0] head, next_head;
    logic [PTR_W-1:0] count, next_count;
    logic [PTR_W-1:0] cursor, next_cursor;
    logic [NSRC-1:0] pend, next_pend;
    code_t ext_code, next_ext_code;
    logic [DATA_W-1:0] next_rdata;
    logic next_err_indicator;
    logic [ESR_W-1:0] next_esr;
    post_t next_remote_post;

    logic signed [PARAM_W-1:0] rounded;
    logic range_err;
    logic [NSRC-1:0] src;

    localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
    localparam logic [PTR_W-1:0] ONE_P = 5'h01;

    // Logical position to physical slot
    function automatic logic [PTR_W-1:0] slot_of(
        input logic [PTR_W-1:0] base,
        input logic [PTR_W-1:0] pos
    );
        logic [PTR_W:0] sum;
        sum = {1'b0, base} + {1'b0, pos};
        if (sum >= {1'b0, DEPTH_P}) begin
            sum = sum - {1'b0, DEPTH_P};
        end
        return sum[PTR_W-1:0];
    endfunction : slot_of

    // One-hot class: {cmd, exec, device, query}
    function automatic logic [3:0] classify(input code_t c);
        logic [3:0] cls;
        cls = 4'h0;
        if (c >= QUERY_LO && c <= QUERY_HI) begin
            cls = 4'h1;
        end else if (c >= EXEC_LO && c <= EXEC_HI) begin
            cls = 4'h4;
        end else if (c >= CMD_LO && c <= CMD_HI) begin
            cls = 4'h8;
        end else if ((c >= DEV_NEG_LO && c <= DEV_NEG_HI) ||
                     (c >= DEV_POS_LO && c <= DEV_POS_HI) ||
                     (c >= DEV_HIGH_LO && c <= DEV_HIGH_HI)) begin
            cls = 4'h2;
        end
        return cls;
    endfunction : classify

    // Round half up first, then compare; a rounded value in range is quiet
    always_comb begin
        rounded = (param_raw + PARAM_HALF) >>> FRAC_W;
        range_err = param_check &&
            (rounded < param_min || rounded > param_max);
    end

    always_comb begin
        src = '0;
        src[0] = err_valid;
        src[1] = selftest_fail;
        src[2] = query_empty_read;
        src[3] = query_data_lost;
        src[4] = range_err;
        src[5] = exec_state_err;
        src[6] = cmd_syntax_err;
        src[7] = cmd_type_err;
        src[8] = cmd_header_err;
        src[9] = 1'b0;
    end

    always_comb begin
        logic [NSRC-1:0] grant;
        logic found;
        logic any_unviewed;
        code_t pcode;
        logic [3:0] cls;
        logic [PTR_W-1:0] slot;
        logic [PTR_W-1:0] lim;
        grant = '0;
        found = 1'b0;
        any_unviewed = 1'b0;
        pcode = CODE_NO_ERROR;
        cls = 4'h0;
        slot = '0;
        lim = '0;
        next_mem = mem;
        next_head = head;
        next_count = count;
        next_cursor = cursor;
        next_ext_code = ext_code;
        next_rdata = '0;
        next_esr = esr;
        next_remote_post = '0;

        if (err_valid) begin
            next_ext_code = err_code;
        end

        // Register reads see the queue as it stood before this cycle
        if (rd) begin
            case (addr)
                OFF_STATUS: begin
                    next_rdata[PTR_W-1:0] = count;
                    if (count != '0) begin
                        next_rdata[8+PTR_W-1:8] = cursor + ONE_P;
                    end
                end
                OFF_VIEW: begin
                    if (count != '0) begin
                        slot = slot_of(head, cursor);
                        next_rdata = DATA_W'(mem[slot].code);
                        next_mem[slot].viewed = 1'b1;
                    end else begin
                        next_rdata = DATA_W'(CODE_NO_ERROR);
                    end
                end
                OFF_ESR: begin
                    next_rdata[ESR_W-1:0] = esr;
                    next_esr = ESR_RESET;
                end
                OFF_POP: begin
                    // Oldest unviewed entry, else the no-error code
                    next_rdata = DATA_W'(CODE_NO_ERROR);
                    for (int i = DEPTH - 1; i >= 0; i--) begin
                        lim = PTR_W'(i);
                        slot = slot_of(head, lim);
                        if (lim < count && !mem[slot].viewed) begin
                            found = 1'b1;
                            pcode = mem[slot].code;
                            grant[0] = 1'b0;
                            next_cursor = lim;
                        end
                    end
                    if (found) begin
                        slot = slot_of(head, next_cursor);
                        next_rdata = DATA_W'(pcode);
                        next_mem[slot].viewed = 1'b1;
                    end
                    found = 1'b0;
                    pcode = CODE_NO_ERROR;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end

        // Stepping an entry onto the display counts as viewing it
        if (wr && addr == OFF_CTRL) begin
            if (wdata[CTRL_CLEAR]) begin
                for (int i = 0; i < DEPTH; i++) begin
                    next_mem[i] = '0;
                end
                next_head = '0;
                next_count = '0;
                next_cursor = '0;
            end else if (wdata[CTRL_NEXT]) begin
                if (count != '0 && cursor + ONE_P < count) begin
                    next_cursor = cursor + ONE_P;
                    slot = slot_of(head, next_cursor);
                    next_mem[slot].viewed = 1'b1;
                end
            end else if (wdata[CTRL_PREV]) begin
                if (cursor != '0) begin
                    next_cursor = cursor - ONE_P;
                    slot = slot_of(head, next_cursor);
                    next_mem[slot].viewed = 1'b1;
                end
            end
        end

        // One post per cycle; lower source index wins, others wait
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i] || src[i]) begin
                grant = '0;
                grant[i] = 1'b1;
            end
        end
        if (grant[0]) begin
            pcode = src[0] ? err_code : ext_code;
        end else if (grant[1]) begin
            pcode = CODE_SELFTEST;
        end else if (grant[2]) begin
            pcode = CODE_QUERY_EMPTY;
        end else if (grant[3]) begin
            pcode = CODE_QUERY_LOST;
        end else if (grant[4]) begin
            pcode = CODE_EXEC_RANGE;
        end else if (grant[5]) begin
            pcode = CODE_EXEC_STATE;
        end else if (grant[6]) begin
            pcode = CODE_CMD_SYNTAX;
        end else if (grant[7]) begin
            pcode = CODE_CMD_DATATYPE;
        end else if (grant[8]) begin
            pcode = CODE_CMD_HEADER;
        end else if (grant[9]) begin
            pcode = unresolved_code;
        end

        if (grant != '0) begin
            cls = classify(pcode);
            next_esr[ESR_QUERY] = next_esr[ESR_QUERY] | cls[0];
            next_esr[ESR_DEVICE] = next_esr[ESR_DEVICE] | cls[1];
            next_esr[ESR_EXEC] = next_esr[ESR_EXEC] | cls[2];
            next_esr[ESR_CMD] = next_esr[ESR_CMD] | cls[3];
            next_remote_post.valid = 1'b1;
            next_remote_post.code = pcode;
            if (next_count == DEPTH_P) begin
                slot = next_head;
                next_head = slot_of(next_head, ONE_P);
                if (next_cursor != '0) begin
                    next_cursor = next_cursor - ONE_P;
                end
            end else begin
                slot = slot_of(next_head, next_count);
                next_count = next_count + ONE_P;
            end
            next_mem[slot].valid = 1'b1;
            next_mem[slot].viewed = 1'b0;
            next_mem[slot].code = pcode;
        end

        // A new event on a granted source in the same cycle is cleared with the grant, not kept
        next_pend = (pend | src) & ~grant;
        if (wr && addr == OFF_CTRL && wdata[CTRL_CLEAR] && unresolved) begin
            next_pend[9] = 1'b1;
        end

        for (int i = 0; i < DEPTH; i++) begin
            any_unviewed = any_unviewed |
                (next_mem[i].valid & ~next_mem[i].viewed);
        end
        next_err_indicator = any_unviewed;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            head <= '0;
            count <= '0;
            cursor <= '0;
            pend <= '0;
            ext_code <= CODE_NO_ERROR;
            rdata <= '0;
            err_indicator <= 1'b0;
            esr <= ESR_RESET;
            remote_post <= '0;
        end else begin
            mem <= next_mem;
            head <= next_head;
            count <= next_count;
            cursor <= next_cursor;
            pend <= next_pend;
            ext_code <= next_ext_code;
            rdata <= next_rdata;
            err_indicator <= next_err_indicator;
            esr <= next_esr;
            remote_post <= next_remote_post;
        end
    end

endmodule : error_queue_status_logger

// [testbench/remote_queue_model.sv]
`timescale 1ns/1ps

// Far-side remote queue: counts what the block hands over
module remote_queue_model
    import error_log_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire post_t remote_post,
    output logic [15:0] post_count,
    output code_t last_code
);
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            post_count <= 16'h0000;
            last_code <= 11'h000;
        end else if (remote_post.valid) begin
            post_count <= post_count + 16'h0001;
            last_code <= remote_post.code;
        end
    end
endmodule : remote_queue_model

// [testbench/error_queue_status_logger_sva.sv]
`timescale 1ns/1ps

module error_queue_status_logger_sva
    import error_log_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic err_valid,
    input wire code_t err_code,
    input wire logic selftest_fail,
    input wire logic err_indicator,
    input wire logic [ESR_W-1:0] esr,
    input wire post_t remote_post
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_ext;
        err_valid |=> remote_post.valid && remote_post.code == $past(err_code);
    endproperty
    a_ext: assert property (p_ext) else $error("external post lost");
    property p_ind;
        remote_post.valid |-> err_indicator;
    endproperty
    a_ind: assert property (p_ind) else $error("indicator low");
    property p_query;
        remote_post.valid && remote_post.code inside {[QUERY_LO:QUERY_HI]}
            |-> esr[ESR_QUERY];
    endproperty
    a_query: assert property (p_query) else $error("query bit");
    property p_dev;
        remote_post.valid && remote_post.code inside {[DEV_NEG_LO:DEV_NEG_HI],
            [DEV_POS_LO:DEV_POS_HI], [DEV_HIGH_LO:DEV_HIGH_HI]}
            |-> esr[ESR_DEVICE];
    endproperty
    a_dev: assert property (p_dev) else $error("device bit");
    property p_exec;
        remote_post.valid && remote_post.code inside {[EXEC_LO:EXEC_HI]}
            |-> esr[ESR_EXEC];
    endproperty
    a_exec: assert property (p_exec) else $error("exec bit");
    property p_cmd;
        remote_post.valid && remote_post.code inside {[CMD_LO:CMD_HI]}
            |-> esr[ESR_CMD];
    endproperty
    a_cmd: assert property (p_cmd) else $error("command bit");
    property p_one;
        $countones(esr & ~$past(esr)) <= 1;
    endproperty
    a_one: assert property (p_one) else $error("two classes set");
    property p_self;
        selftest_fail && !err_valid
            |=> remote_post.valid && remote_post.code == CODE_SELFTEST;
    endproperty
    a_self: assert property (p_self) else $error("self-test post");
endmodule : error_queue_status_logger_sva

bind error_queue_status_logger error_queue_status_logger_sva sva_i (
    .core_clk(core_clk), .reset(reset), .err_valid(err_valid),
    .err_code(err_code), .selftest_fail(selftest_fail),
    .err_indicator(err_indicator), .esr(esr), .remote_post(remote_post));

// [testbench/error_queue_status_logger_tb.sv]
`timescale 1ns/1ps

module error_queue_status_logger_tb;
    import error_log_pkg::*;
    logic core_clk, reset, wr, rd, err_valid, param_check, unresolved;
    logic rd_q, err_indicator;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [ESR_W-1:0] esr;
    logic [6:0] src;
    logic signed [PARAM_W-1:0] param_raw, param_min, param_max;
    logic [15:0] post_count;
    logic [31:0] note;
    code_t err_code, unresolved_code;
    post_t remote_post;
    int bad_count, compares, total;
    logic [31:0] exp_rd[$];
    code_t exp_post[$];
    code_t rnd[32];
    code_t cls_code[15] = '{-11'sh1F3, -11'sh190, -11'sh18F, -11'sh12C,
        11'sh0C9, 11'sh2BF, 11'sh320, 11'sh32A, -11'sh12B, -11'sh0C8,
        -11'sh0C7, -11'sh064, 11'sh2C0, 11'sh32B, -11'sh063};
    logic [7:0] cls_esr[15] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08,
        8'h08, 8'h08, 8'h10, 8'h10, 8'h20, 8'h20, 8'h00, 8'h00, 8'h00};
    code_t src_code[7] = '{CODE_SELFTEST, CODE_QUERY_EMPTY, CODE_QUERY_LOST,
        CODE_EXEC_STATE, CODE_CMD_SYNTAX, CODE_CMD_DATATYPE, CODE_CMD_HEADER};
    logic [7:0] src_esr[7] = '{8'h08, 8'h04, 8'h04, 8'h10, 8'h20, 8'h20,
        8'h20};

    error_queue_status_logger error_queue_status_logger_i (
        .core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .err_valid(err_valid), .err_code(err_code),
        .selftest_fail(src[0]), .query_empty_read(src[1]),
        .query_data_lost(src[2]), .param_check(param_check),
        .param_raw(param_raw), .param_min(param_min),
        .param_max(param_max), .exec_state_err(src[3]),
        .cmd_syntax_err(src[4]), .cmd_type_err(src[5]),
        .cmd_header_err(src[6]), .unresolved(unresolved),
        .unresolved_code(unresolved_code), .rdata(rdata),
        .err_indicator(err_indicator), .esr(esr), .remote_post(remote_post));
    remote_queue_model remote_queue_model_i (.core_clk(core_clk),
        .reset(reset), .remote_post(remote_post), .post_count(post_count),
        .last_code());

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [15:0] sx(code_t c);
        return {{5{c[10]}}, c};
    endfunction : sx
    task automatic check(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : check
    task automatic wrap_up();
        $display("totals bad_count %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic rd_reg(logic [3:0] a, logic [15:0] e,
                          logic [15:0] m = 16'hFFFF);
        exp_rd.push_back({m, e & m});
        @(posedge core_clk) begin addr <= a; rd <= 1'b1; end
        @(posedge core_clk) rd <= 1'b0;
    endtask : rd_reg
    task automatic wr_reg(logic [3:0] a, logic [15:0] d);
        @(posedge core_clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge core_clk) wr <= 1'b0;
    endtask : wr_reg
    task automatic post_ext(code_t c);
        exp_post.push_back(c);
        total++;
        @(posedge core_clk) begin err_valid <= 1'b1; err_code <= c; end
        @(posedge core_clk) err_valid <= 1'b0;
    endtask : post_ext
    task automatic pulse_src(int i);
        exp_post.push_back(src_code[i]);
        total++;
        @(posedge core_clk) src <= 7'h01 << i;
        @(posedge core_clk) src <= 7'h00;
    endtask : pulse_src

    // Values stand one cycle after their cause, so look one edge late
    always @(posedge core_clk) begin
        rd_q <= rd;
        if (rd_q) begin
            note = exp_rd.pop_front();
            check("rdata", note[15:0], rdata & note[31:16]);
        end
        if (remote_post.valid) begin
            if (exp_post.size() == 0) check("unexpected post", 16'h0, 16'h1);
            else check("post code", sx(exp_post.pop_front()),
                       sx(remote_post.code));
        end
    end

    initial begin
        {wr, rd, err_valid, param_check, unresolved, addr, wdata} = '0;
        {src, param_raw, param_min, param_max, err_code} = '0;
        unresolved_code = 11'h000;
        reset = 1'b1;
        void'($urandom(32'hFEB7FA36));
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd_reg(OFF_ESR, 16'h0000);
        rd_reg(OFF_VIEW, 16'h0000);
        rd_reg(4'hF, 16'h0000);
        for (int i = 0; i < 15; i++) begin
            post_ext(cls_code[i]);
            rd_reg(OFF_ESR, {8'h00, cls_esr[i]});
        end
        for (int i = 0; i < 7; i++) begin
            pulse_src(i);
            rd_reg(OFF_ESR, {8'h00, src_esr[i]});
        end
        // 10.5 rounds to 11: inside the limit, so no post may appear
        @(posedge core_clk) begin
            param_raw <= 16'sh00A8;
            param_max <= 16'sh000B;
            param_check <= 1'b1;
        end
        @(posedge core_clk) param_check <= 1'b0;
        exp_post.push_back(CODE_EXEC_RANGE);
        total++;
        @(posedge core_clk) begin
            param_max <= 16'sh000A;
            param_check <= 1'b1;
        end
        @(posedge core_clk) param_check <= 1'b0;
        rd_reg(OFF_ESR, 16'h0010);
        // Below the lower limit after rounding posts as well
        exp_post.push_back(CODE_EXEC_RANGE);
        total++;
        @(posedge core_clk) begin
            param_min <= 16'sh000C;
            param_max <= 16'sh000F;
            param_check <= 1'b1;
        end
        @(posedge core_clk) param_check <= 1'b0;
        rd_reg(OFF_ESR, 16'h0010);
        wr_reg(OFF_CTRL, 16'h0004);
        for (int i = 0; i < 32; i++) begin
            rnd[i] = -11'sh0C8 - code_t'($urandom % 100);
            post_ext(rnd[i]);
        end
        rd_reg(OFF_STATUS, 16'h001E, 16'h001F);
        rd_reg(OFF_POP, sx(rnd[2]));
        wr_reg(OFF_CTRL, 16'h0004);
        post_ext(-11'sh065);
        post_ext(-11'sh066);
        post_ext(-11'sh067);
        // Let the edge that stored the last entry settle first
        @(negedge core_clk);
        check("indicator", 16'h1, {15'h0, err_indicator});
        rd_reg(OFF_POP, sx(-11'sh065));
        rd_reg(OFF_STATUS, 16'h0103);
        wr_reg(OFF_CTRL, 16'h0001);
        rd_reg(OFF_VIEW, sx(-11'sh066));
        wr_reg(OFF_CTRL, 16'h0002);
        rd_reg(OFF_VIEW, sx(-11'sh065));
        wr_reg(OFF_CTRL, 16'h0001);
        wr_reg(OFF_CTRL, 16'h0001);
        rd_reg(OFF_VIEW, sx(-11'sh067));
        rd_reg(OFF_POP, 16'h0000);
        repeat (2) @(posedge core_clk);
        check("indicator", 16'h0, {15'h0, err_indicator});
        unresolved <= 1'b1;
        unresolved_code <= -11'sh0FA;
        exp_post.push_back(-11'sh0FA);
        total++;
        wr_reg(OFF_CTRL, 16'h0004);
        repeat (5) @(posedge core_clk);
        unresolved <= 1'b0;
        rd_reg(OFF_STATUS, 16'h0001, 16'h001F);
        rd_reg(OFF_POP, sx(-11'sh0FA));
        wr_reg(OFF_CTRL, 16'h0004);
        rd_reg(OFF_VIEW, 16'h0000);
        rd_reg(OFF_STATUS, 16'h0000);
        repeat (3) @(posedge core_clk);
        check("pending posts", 16'h0, 16'(exp_post.size()));
        check("remote count", 16'(total), post_count);
        wrap_up();
    end

    initial begin
        #2000000;
        bad_count++;
        wrap_up();
    end
endmodule : error_queue_status_logger_tb
